// ---- core/cdx_pkg.sv ----
// cdx_pkg: constants for the complement / decrement execution block
// assumes: 12-bit instruction words, 8-bit data path, 32 file registers
package cdx_pkg;

  // ****************************************************************
  // instruction fields
  // ****************************************************************
  localparam int INSTR_W = 12;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 6;
  localparam int DEST_BIT = 5;
  localparam int ADDR_HI = 4;
  localparam int ADDR_LO = 0;

  // ****************************************************************
  // opcodes (upper six bits)
  // ****************************************************************
  localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
  localparam logic [5:0] OPC_DECREMENT = 6'h03;
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [7:0] DATA_ONE = 8'h01;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [11:0] NOP_WORD = 12'h000;
  localparam logic DEST_W = 1'b0;

  // ****************************************************************
  // execution states
  // ****************************************************************
  typedef enum logic [1:0] {
    CDX_RUN = 2'b01,
    CDX_SKIP = 2'b10
  } cdx_state_t;

endpackage : cdx_pkg

// ---- core/cdx_alu.sv ----
// cdx_alu: combinational result and zero test for the three operations
// assumes: operand already read from the addressed file register
`timescale 1ns/1ps
`default_nettype none

module cdx_alu (
  // operation select
  input wire logic do_complement,
  // operand
  input wire logic [7:0] operand,
  // result
  output logic [7:0] result,
  output logic result_zero
);

  always_comb
  begin
    if (do_complement)
    begin
      result = ~operand;
    end
    else
    begin
      result = operand - cdx_pkg::DATA_ONE;
    end
    result_zero = (result == cdx_pkg::DATA_ZERO);
  end

endmodule : cdx_alu

`default_nettype wire

// ---- core/cdx_exec.sv ----
// cdx_exec: decodes and executes complement, decrement and decrement-skip
// assumes: one instruction per sys_clk cycle; file register read is combinational
// through file_addr / file_rdata; other opcodes are handled elsewhere
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - complement opcode writes inverted file register to destination, updates zero, one cycle
// - destination bit 0 selects working register, 1 writes back to file register
// - decrement-skip writes file minus one to destination, leaves all flags alone
// - zero result of decrement-skip replaces next fetched instruction with no-op
module cdx_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  // file register read
  output logic [4:0] file_addr,
  input wire logic [7:0] file_rdata,
  // file register write
  output logic file_we_q,
  output logic [4:0] file_waddr_q,
  output logic [7:0] file_wdata_q,
  // working register and zero flag
  output logic [7:0] w_q,
  output logic zero_flag_q,
  // skip status
  output logic nop_exec_q,
  output logic done_q
);

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [5:0] opc;
  logic dest;
  logic [4:0] addr;
  logic in_skip;
  logic is_com;
  logic is_dec;
  logic is_dsz;
  logic hit;
  logic [7:0] result;
  logic result_zero;
  cdx_pkg::cdx_state_t state_q;
  cdx_pkg::cdx_state_t state_d;

  assign opc = instr[cdx_pkg::OPC_HI:cdx_pkg::OPC_LO];
  assign dest = instr[cdx_pkg::DEST_BIT];
  assign addr = instr[cdx_pkg::ADDR_HI:cdx_pkg::ADDR_LO];
  assign in_skip = (state_q == cdx_pkg::CDX_SKIP);
  assign is_com = instr_valid && !in_skip && (opc == cdx_pkg::OPC_COMPLEMENT);
  assign is_dec = instr_valid && !in_skip && (opc == cdx_pkg::OPC_DECREMENT);
  assign is_dsz = instr_valid && !in_skip && (opc == cdx_pkg::OPC_DEC_SKIP);
  assign hit = is_com || is_dec || is_dsz;
  // output from combinational address: read happens in the issue cycle
  assign file_addr = addr;

  cdx_alu u_alu (
    .do_complement(is_com),
    .operand(file_rdata),
    .result(result),
    .result_zero(result_zero)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  logic file_we_d;
  logic [4:0] file_waddr_d;
  logic [7:0] file_wdata_d;
  logic [7:0] w_d;
  logic zero_flag_d;
  logic nop_exec_d;
  logic done_d;

  always_comb
  begin
    state_d = state_q;
    file_we_d = 1'b0;
    file_waddr_d = addr;
    file_wdata_d = result;
    w_d = w_q;
    zero_flag_d = zero_flag_q;
    nop_exec_d = 1'b0;
    done_d = 1'b0;
    case (state_q)
      cdx_pkg::CDX_RUN:
      begin
        if (hit)
        begin
          done_d = !(is_dsz && result_zero);
          if (dest == cdx_pkg::DEST_W)
          begin
            w_d = result;
          end
          else
          begin
            file_we_d = 1'b1;
          end
          // decrement-skip never reaches the zero flag
          if (is_com || is_dec)
          begin
            zero_flag_d = result_zero;
          end
          if (is_dsz && result_zero)
          begin
            state_d = cdx_pkg::CDX_SKIP;
          end
        end
      end
      cdx_pkg::CDX_SKIP:
      begin
        // fetched word is discarded; a no-op runs instead
        if (instr_valid)
        begin
          nop_exec_d = 1'b1;
          done_d = 1'b1;
          state_d = cdx_pkg::CDX_RUN;
        end
      end
      default:
      begin
        state_d = cdx_pkg::CDX_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= cdx_pkg::CDX_RUN;
      file_we_q <= 1'b0;
      file_waddr_q <= 5'h00;
      file_wdata_q <= cdx_pkg::DATA_ZERO;
      w_q <= cdx_pkg::W_RESET;
      zero_flag_q <= 1'b0;
      nop_exec_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      file_we_q <= file_we_d;
      file_waddr_q <= file_waddr_d;
      file_wdata_q <= file_wdata_d;
      w_q <= w_d;
      zero_flag_q <= zero_flag_d;
      nop_exec_q <= nop_exec_d;
      done_q <= done_d;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_com_result;
    @(posedge sys_clk) disable iff (!rstn)
    is_com |=> (zero_flag_q == ((~$past(file_rdata)) == cdx_pkg::DATA_ZERO)) && done_q;
  endproperty
  a_com_result: assert property (p_com_result) else $error("complement result wrong");

  property p_com_value;
    @(posedge sys_clk) disable iff (!rstn)
    is_com |=> file_wdata_q == ~$past(file_rdata);
  endproperty
  a_com_value: assert property (p_com_value) else $error("complement value wrong");

  property p_dest_file;
    @(posedge sys_clk) disable iff (!rstn)
    (hit && dest) |=> file_we_q && (file_waddr_q == $past(addr)) && $stable(w_q);
  endproperty
  a_dest_file: assert property (p_dest_file) else $error("file write-back missing");

  property p_dest_w;
    @(posedge sys_clk) disable iff (!rstn)
    (hit && !dest) |=> !file_we_q && (w_q == $past(result));
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("working register not loaded");

  property p_dec_value;
    @(posedge sys_clk) disable iff (!rstn)
    is_dec |=> (file_wdata_q == $past(file_rdata) - cdx_pkg::DATA_ONE) && done_q;
  endproperty
  a_dec_value: assert property (p_dec_value) else $error("decrement value wrong");

  property p_dsz_flags;
    @(posedge sys_clk) disable iff (!rstn)
    is_dsz |=> $stable(zero_flag_q);
  endproperty
  a_dsz_flags: assert property (p_dsz_flags) else $error("skip op changed zero flag");

  property p_skip_nop;
    @(posedge sys_clk) disable iff (!rstn)
    (is_dsz && result_zero) |=> !done_q && !nop_exec_q && in_skip;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skip sequence broken");

  property p_skip_hold;
    @(posedge sys_clk) disable iff (!rstn)
    (in_skip && instr_valid) |=> $stable(w_q) && $stable(zero_flag_q) && !file_we_q;
  endproperty
  a_skip_hold: assert property (p_skip_hold) else $error("discarded word took effect");

  property p_dsz_one;
    @(posedge sys_clk) disable iff (!rstn)
    (is_dsz && !result_zero) |=> done_q && !in_skip;
  endproperty
  a_dsz_one: assert property (p_dsz_one) else $error("nonzero skip op not single cycle");

  property p_skip_two;
    @(posedge sys_clk) disable iff (!rstn)
    (is_dsz && result_zero) ##1 instr_valid |=> nop_exec_q && done_q && !file_we_q;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("no-op not executed");

  property p_zero_set;
    @(posedge sys_clk) disable iff (!rstn)
    (is_com || is_dec) |=> zero_flag_q == ($past(result) == cdx_pkg::DATA_ZERO);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero flag wrong");

endmodule : cdx_exec

`default_nettype wire

// ---- verif/cdx_tb.sv ----
// testbench for cdx_exec: complement, decrement and decrement-skip
// assumes: bench acts as fetch unit and file register read port
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  logic [11:0] instr = 12'h000;
  logic [7:0] file_rdata = 8'h00;
  logic [4:0] file_addr;
  logic file_we_q;
  logic [4:0] file_waddr_q;
  logic [7:0] file_wdata_q;
  logic [7:0] w_q;
  logic zero_flag_q;
  logic nop_exec_q;
  logic done_q;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;

  cdx_exec dut_u (
    .sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
    .file_addr(file_addr), .file_rdata(file_rdata), .file_we_q(file_we_q),
    .file_waddr_q(file_waddr_q), .file_wdata_q(file_wdata_q), .w_q(w_q),
    .zero_flag_q(zero_flag_q), .nop_exec_q(nop_exec_q), .done_q(done_q)
  );

  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task test_done;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done

  task cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_byte

  task cmp_bit(input logic got, input logic exp);
    cmp_byte({7'h00, got}, {7'h00, exp});
  endtask : cmp_bit

  // present one word and operand, then let the executing edge land
  task run(input logic [5:0] op, input logic d, input logic [4:0] a, input logic [7:0] rd);
    instr = {op, d, a};
    file_rdata = rd;
    instr_valid = 1'b1;
    #1;
    cmp_byte({3'h0, file_addr}, {3'h0, a});
    @(posedge sys_clk);
    #2;
  endtask : run

  task idle;
    instr_valid = 1'b0;
    @(posedge sys_clk);
    #2;
  endtask : idle

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_comp;
    run(cdx_pkg::OPC_COMPLEMENT, 1'b0, 5'h0f, 8'h13);
    cmp_byte(w_q, 8'hec);
    cmp_bit(zero_flag_q, 1'b0);
    cmp_bit(done_q, 1'b1);
    cmp_bit(file_we_q, 1'b0);
    run(cdx_pkg::OPC_COMPLEMENT, 1'b1, 5'h1f, 8'hff);
    cmp_bit(file_we_q, 1'b1);
    cmp_byte(file_wdata_q, 8'h00);
    cmp_byte({3'h0, file_waddr_q}, 8'h1f);
    cmp_bit(zero_flag_q, 1'b1);
    cmp_byte(w_q, 8'hec);
    idle();
  endtask : t_comp

  task t_dec;
    run(cdx_pkg::OPC_DECREMENT, 1'b0, 5'h02, 8'h01);
    cmp_byte(w_q, 8'h00);
    cmp_bit(zero_flag_q, 1'b1);
    cmp_bit(done_q, 1'b1);
    run(cdx_pkg::OPC_DECREMENT, 1'b1, 5'h00, 8'h00);
    cmp_byte(file_wdata_q, 8'hff);
    cmp_bit(file_we_q, 1'b1);
    cmp_bit(zero_flag_q, 1'b0);
    idle();
  endtask : t_dec

  task t_skip;
    run(cdx_pkg::OPC_DEC_SKIP, 1'b1, 5'h05, 8'h01);
    cmp_byte(file_wdata_q, 8'h00);
    cmp_bit(zero_flag_q, 1'b0);
    cmp_bit(done_q, 1'b0);
    run(cdx_pkg::OPC_COMPLEMENT, 1'b0, 5'h06, 8'h00);
    cmp_bit(nop_exec_q, 1'b1);
    cmp_bit(done_q, 1'b1);
    cmp_bit(file_we_q, 1'b0);
    cmp_byte(w_q, 8'h00);
    run(cdx_pkg::OPC_DECREMENT, 1'b0, 5'h07, 8'h01);
    run(cdx_pkg::OPC_DEC_SKIP, 1'b0, 5'h04, 8'h06);
    cmp_byte(w_q, 8'h05);
    cmp_bit(zero_flag_q, 1'b1);
    cmp_bit(done_q, 1'b1);
    cmp_bit(nop_exec_q, 1'b0);
    idle();
  endtask : t_skip

  task t_gap_reset;
    run(cdx_pkg::OPC_DEC_SKIP, 1'b0, 5'h08, 8'h01);
    cmp_byte(w_q, 8'h00);
    cmp_bit(done_q, 1'b0);
    idle();
    cmp_bit(nop_exec_q, 1'b0);
    cmp_bit(done_q, 1'b0);
    run(cdx_pkg::OPC_DECREMENT, 1'b0, 5'h09, 8'h10);
    cmp_bit(nop_exec_q, 1'b1);
    cmp_byte(w_q, 8'h00);
    cmp_bit(zero_flag_q, 1'b1);
    run(cdx_pkg::OPC_DEC_SKIP, 1'b1, 5'h0a, 8'h01);
    cmp_bit(file_we_q, 1'b1);
    instr_valid = 1'b0;
    rstn = 1'b0;
    @(posedge sys_clk);
    #2;
    cmp_bit(zero_flag_q, 1'b0);
    cmp_bit(file_we_q, 1'b0);
    rstn = 1'b1;
    run(cdx_pkg::OPC_COMPLEMENT, 1'b0, 5'h0b, 8'h5a);
    cmp_byte(w_q, 8'ha5);
    cmp_bit(nop_exec_q, 1'b0);
    cmp_bit(done_q, 1'b1);
    idle();
  endtask : t_gap_reset

  // ****************************************************************
  // main sequence and timeout
  // ****************************************************************
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      err_total++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    #2;
    rstn = 1'b1;
    cmp_byte(w_q, cdx_pkg::W_RESET);
    cmp_bit(zero_flag_q, 1'b0);
    t_comp();
    t_dec();
    t_skip();
    t_gap_reset();
    test_done();
  end
endmodule : testbench

`default_nettype wire
